//--- pkg/fad_map.svh
/*
  Register offsets, field positions, reset values, opcode fields and clock counts
  of the flag/arithmetic opcode decoder. Assumes inclusion by bare name.
*/
`ifndef FAD_MAP_SVH
`define FAD_MAP_SVH
`define FAD_OFS_INSN 8'h00
`define FAD_OFS_CTRL 8'h04
`define FAD_OFS_STAT 8'h08
`define FAD_OFS_FLD 8'h0C
`define FAD_CTRL_START 0
`define FAD_CTRL_CLR 1
`define FAD_CTRL_MODE 5:4
`define FAD_INSN_RST 32'h0000_0000
`define FAD_MODE_RST 2'h0
`define FAD_RESP_OK 2'h0
`define FAD_RESP_ERR 2'h2
`define FAD_OPC_CMC 8'hF5
`define FAD_OPC_FLAGS_TO_ACC_HIGH_OP 8'h9F
`define FAD_OPC_ACC_HIGH_TO_FLAGS_OP 8'h9E
`define FAD_OPC_POP_FLAGS_OP 8'h9D
`define FAD_OPC_PUSH_FLAGS_OP 8'h9C
`define FAD_OPC_ESC 8'h0F
`define FAD_OPC_CLTS2 8'h06
`define FAD_TOP6_ADD 6'h00
`define FAD_TOP6_ADC 6'h04
`define FAD_TOP6_SUB 6'h0A
`define FAD_TOP6_IMM 6'h20
`define FAD_TOP7_ADD_ACC 7'h02
`define FAD_TOP7_ADC_ACC 7'h0A
`define FAD_TOP7_INC 7'h7F
`define FAD_TOP5_INC_SHORT 5'h08
`define FAD_MID_ADD 3'h0
`define FAD_MID_ADC 3'h2
`define FAD_MID_INC 3'h0
`define FAD_MOD_REG 2'h3
`define FAD_CYC_CMC 4'h2
`define FAD_CYC_FLAGS_TO_ACC_HIGH_OP 4'h2
`define FAD_CYC_ACC_HIGH_TO_FLAGS_OP 4'h3
`define FAD_CYC_POP_FLAGS_OP 4'h5
`define FAD_CYC_PUSH_FLAGS_OP 4'h4
`define FAD_CYC_CLEAR_TASK_SWITCHED_OP 4'h5
`define FAD_CYC_CLI 4'h3
`define FAD_CYC_STI 4'h3
`define FAD_CYC_STC 4'h2
`define FAD_CYC_STD 4'h2
`define FAD_CYC_RR 4'h2
`define FAD_CYC_TOMEM 4'h7
`define FAD_CYC_FROMMEM 4'h6
`define FAD_CYC_INC_MEM 4'h6
`endif

//--- pkg/fad_pkg.sv
/*
  Types of the flag/arithmetic opcode decoder: operation classes and timer states.
  Assumes nothing of its surroundings.
*/
package fad_pkg;
  typedef enum logic [3:0] {
    FAD_OP_NONE = 4'h0,
    FAD_OP_CMC = 4'h1,
    FAD_OP_FLAGS_TO_ACC_HIGH_OP = 4'h2,
    FAD_OP_ACC_HIGH_TO_FLAGS_OP = 4'h3,
    FAD_OP_POP_FLAGS_OP = 4'h4,
    FAD_OP_PUSH_FLAGS_OP = 4'h5,
    FAD_OP_CLEAR_TASK_SWITCHED_OP = 4'h6,
    FAD_OP_CLI = 4'h7,
    FAD_OP_STI = 4'h8,
    FAD_OP_STC = 4'h9,
    FAD_OP_STD = 4'hA,
    FAD_OP_ADD = 4'hB,
    FAD_OP_ADC = 4'hC,
    FAD_OP_INC = 4'hD,
    FAD_OP_SUB = 4'hE
  } fad_op_t;
  typedef enum logic {
    FAD_T_IDLE = 1'b0,
    FAD_T_RUN = 1'b1
  } fad_tstate_t;
endpackage : fad_pkg

//--- pkg/fad_dec_if.sv
/*
  Carrier between the register file and the opcode decoder.
  Assumes the decoder is purely combinational.
*/
`timescale 1ns/1ps
interface fad_dec_if;
  import fad_pkg::*;
  logic [31:0] insn;
  fad_op_t op;
  logic [3:0] cycles;
  logic valid;
  logic w;
  logic d;
  logic mem;
  logic two_byte;
  logic [1:0] mod_f;
  logic [2:0] reg_f;
  logic [2:0] rm_f;
  modport dec (input insn, output op, cycles, valid, w, d, mem, two_byte, mod_f, reg_f, rm_f);
  modport use_side (output insn, input op, cycles, valid, w, d, mem, two_byte, mod_f, reg_f, rm_f);
endinterface : fad_dec_if

//--- rtl/fad_decode.sv
/*
  Combinational decoder: byte 0 is the opcode, byte 1 the operand selector byte
  or the second opcode byte. Assumes the instruction word is held stable by its owner.
*/
`timescale 1ns/1ps
`include "fad_map.svh"
module fad_decode
  import fad_pkg::*;
#(
  parameter logic [7:0] CLR_IE_OPC = 8'hF4,
  parameter logic [7:0] SET_IE_OPC = 8'hF6,
  parameter logic [7:0] SET_CY_OPC = 8'hF2,
  parameter logic [7:0] SET_DIR_OPC = 8'hF3
)(
  fad_dec_if.dec dif
);
  logic [7:0] b0;
  logic [7:0] b1;
  logic is_mem;
  assign b0 = dif.insn[7:0];
  assign b1 = dif.insn[15:8];
  assign is_mem = (b1[7:6] != `FAD_MOD_REG);
  assign dif.mod_f = b1[7:6];
  assign dif.rm_f = b1[2:0];

  always_comb
  begin
    dif.op = FAD_OP_NONE;
    dif.cycles = 4'h0;
    dif.w = 1'b0;
    dif.d = 1'b0;
    dif.mem = 1'b0;
    dif.two_byte = 1'b0;
    dif.reg_f = b1[5:3];
    if (b0 == `FAD_OPC_CMC)
    begin
      dif.op = FAD_OP_CMC;
      dif.cycles = `FAD_CYC_CMC;
    end
    else if (b0 == `FAD_OPC_FLAGS_TO_ACC_HIGH_OP)
    begin
      dif.op = FAD_OP_FLAGS_TO_ACC_HIGH_OP;
      dif.cycles = `FAD_CYC_FLAGS_TO_ACC_HIGH_OP;
    end
    else if (b0 == `FAD_OPC_ACC_HIGH_TO_FLAGS_OP)
    begin
      dif.op = FAD_OP_ACC_HIGH_TO_FLAGS_OP;
      dif.cycles = `FAD_CYC_ACC_HIGH_TO_FLAGS_OP;
    end
    else if (b0 == `FAD_OPC_POP_FLAGS_OP)
    begin
      dif.op = FAD_OP_POP_FLAGS_OP;
      dif.cycles = `FAD_CYC_POP_FLAGS_OP;
    end
    else if (b0 == `FAD_OPC_PUSH_FLAGS_OP)
    begin
      dif.op = FAD_OP_PUSH_FLAGS_OP;
      dif.cycles = `FAD_CYC_PUSH_FLAGS_OP;
    end
    else if (b0 == `FAD_OPC_ESC && b1 == `FAD_OPC_CLTS2)
    begin
      dif.op = FAD_OP_CLEAR_TASK_SWITCHED_OP;
      dif.cycles = `FAD_CYC_CLEAR_TASK_SWITCHED_OP;
      dif.two_byte = 1'b1;
    end
    else if (b0 == CLR_IE_OPC)
    begin
      dif.op = FAD_OP_CLI;
      dif.cycles = `FAD_CYC_CLI;
    end
    else if (b0 == SET_IE_OPC)
    begin
      dif.op = FAD_OP_STI;
      dif.cycles = `FAD_CYC_STI;
    end
    else if (b0 == SET_CY_OPC || b0 == SET_DIR_OPC)
    begin
      dif.op = (b0 == SET_CY_OPC) ? FAD_OP_STC : FAD_OP_STD;
      dif.cycles = (b0 == SET_CY_OPC) ? `FAD_CYC_STC : `FAD_CYC_STD;
    end
    else if (b0[7:1] == `FAD_TOP7_ADD_ACC || b0[7:1] == `FAD_TOP7_ADC_ACC)
    begin
      // Short accumulator forms: immediate follows, no selector byte
      dif.op = (b0[7:1] == `FAD_TOP7_ADD_ACC) ? FAD_OP_ADD : FAD_OP_ADC;
      dif.cycles = `FAD_CYC_RR;
      dif.w = b0[0];
      dif.reg_f = 3'h0;
    end
    else if (b0[7:2] == `FAD_TOP6_ADD || b0[7:2] == `FAD_TOP6_ADC ||
             (b0[7:2] == `FAD_TOP6_SUB && !is_mem))
    begin
      dif.op = (b0[7:2] == `FAD_TOP6_ADD) ? FAD_OP_ADD :
               (b0[7:2] == `FAD_TOP6_ADC) ? FAD_OP_ADC : FAD_OP_SUB;
      dif.w = b0[0];
      dif.d = b0[1];
      dif.mem = is_mem;
      dif.cycles = !is_mem ? `FAD_CYC_RR : (b0[1] ? `FAD_CYC_FROMMEM : `FAD_CYC_TOMEM);
    end
    else if (b0[7:2] == `FAD_TOP6_IMM && (b1[5:3] == `FAD_MID_ADD || b1[5:3] == `FAD_MID_ADC))
    begin
      dif.op = (b1[5:3] == `FAD_MID_ADD) ? FAD_OP_ADD : FAD_OP_ADC;
      dif.w = b0[0];
      dif.mem = is_mem;
      dif.cycles = is_mem ? `FAD_CYC_TOMEM : `FAD_CYC_RR;
    end
    else if (b0[7:1] == `FAD_TOP7_INC && b1[5:3] == `FAD_MID_INC)
    begin
      dif.op = FAD_OP_INC;
      dif.w = b0[0];
      dif.mem = is_mem;
      dif.cycles = is_mem ? `FAD_CYC_INC_MEM : `FAD_CYC_RR;
    end
    else if (b0[7:3] == `FAD_TOP5_INC_SHORT)
    begin
      dif.op = FAD_OP_INC;
      dif.w = 1'b1;
      dif.reg_f = b0[2:0];
      dif.cycles = `FAD_CYC_RR;
    end
  end

  assign dif.valid = (dif.op != FAD_OP_NONE);
endmodule : fad_decode

//--- rtl/fad_timer.sv
/*
  Duration timer: busy for exactly the loaded number of clocks, then a one-cycle done.
  Assumes a start is given only with a count of at least one.
*/
`timescale 1ns/1ps
module fad_timer
  import fad_pkg::*;
#(
  parameter int CW = 4
)(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire logic [CW-1:0] i_cycles,
  output logic o_busy,
  output logic o_done
);
  fad_tstate_t state_ff, nxt_state;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_done = 1'b0;
    case (state_ff)
      FAD_T_IDLE:
      begin
        if (i_start)
        begin
          nxt_state = FAD_T_RUN;
          nxt_cnt = i_cycles - 1'b1;
        end
      end
      FAD_T_RUN:
      begin
        if (cnt_ff == '0)
        begin
          nxt_state = FAD_T_IDLE;
          nxt_done = 1'b1;
        end
        else
        begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default:
      begin
        nxt_state = FAD_T_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_ff <= FAD_T_IDLE;
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign o_busy = (state_ff == FAD_T_RUN);
  assign o_done = done_ff;

  busy_len_two_a: assert property (@(posedge i_clk) disable iff (i_rst)
    (i_start && state_ff == FAD_T_IDLE && i_cycles == 2) |=> o_busy [*2] ##1 (!o_busy && o_done))
    else $error("two-clock run has wrong length");
  done_after_busy_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $fell(o_busy) |-> o_done)
    else $error("done not raised when busy ended");
endmodule : fad_timer

//--- rtl/fad_top.sv
/*
  Flag-control and first-arithmetic-group opcode decoder and timer behind an
  AXI4-Lite register slave. Assumes a single 200 MHz clock and an AXI4-Lite master
  that keeps valid and payload stable until taken.
*/
// The address map and the AXI4-Lite register port are this design's own decisions.
// Contract
// - Opcode F5 decodes as complement carry, two clocks.
// - Opcode 9F decodes as flags to accumulator high byte, two clocks.
// - Opcode 9E decodes as accumulator high byte to flags, three clocks.
// - Bytes 0F 06 decode as clear task switched, five clocks.
// - Clear interrupt enable takes three clocks; opcode is a parameter.
// - Set interrupt enable takes three clocks; opcode is a parameter.
// - Set carry and set direction take two clocks; distinct parameter opcodes.
// - Short accumulator immediate add 0000010w takes two clocks.
// - Add to memory seven clocks, memory into register six clocks.
// - Immediate add, middle field 000, two clocks register, seven memory.
// - Register add with carry 000100dw takes two clocks.
// - Add with carry to memory seven clocks, from memory six.
// - Immediate add with carry, middle field 010, two or seven clocks.
// - Increment 1111111w middle 000, two clocks register, six memory.
// - Register subtract 001010dw takes two clocks.
`timescale 1ns/1ps
`include "fad_map.svh"
module fad_top
  import fad_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter logic [7:0] CLR_IE_OPC = 8'hF4,
  parameter logic [7:0] SET_IE_OPC = 8'hF6,
  parameter logic [7:0] SET_CY_OPC = 8'hF2,
  parameter logic [7:0] SET_DIR_OPC = 8'hF3
)(
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [ADDR_W-1:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  output logic O_BUSY
);
  fad_dec_if dif ();

  logic aw_held_ff, nxt_aw_held;
  logic [ADDR_W-1:0] awaddr_ff, nxt_awaddr;
  logic w_held_ff, nxt_w_held;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;
  logic [31:0] insn_ff, nxt_insn;
  logic [1:0] mode_ff, nxt_mode;
  logic done_ff, nxt_done;
  logic ill_ff, nxt_ill;
  logic [3:0] lat_cyc_ff, nxt_lat_cyc;

  logic aw_now;
  logic w_now;
  logic do_wr;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic start_req;
  logic clr_req;
  logic start_ok;
  logic tmr_busy;
  logic tmr_done;
  logic [31:0] stat_word;
  logic [31:0] fld_word;

  assign dif.insn = insn_ff;

  fad_decode #(
    .CLR_IE_OPC(CLR_IE_OPC),
    .SET_IE_OPC(SET_IE_OPC),
    .SET_CY_OPC(SET_CY_OPC),
    .SET_DIR_OPC(SET_DIR_OPC)
  ) u_decode (
    .dif(dif)
  );

  fad_timer #(
    .CW(4)
  ) u_timer (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .i_start(start_ok),
    .i_cycles(dif.cycles),
    .o_busy(tmr_busy),
    .o_done(tmr_done)
  );

  // Write channel acceptance, address and data in either order
  assign O_AWREADY = !aw_held_ff && !bvalid_ff;
  assign O_WREADY = !w_held_ff && !bvalid_ff;
  assign aw_now = aw_held_ff || (I_AWVALID && O_AWREADY);
  assign w_now = w_held_ff || (I_WVALID && O_WREADY);
  assign do_wr = aw_now && w_now && !bvalid_ff;
  assign wr_addr = aw_held_ff ? awaddr_ff : I_AWADDR;
  assign wr_data = w_held_ff ? wdata_ff : I_WDATA;
  assign wr_strb = w_held_ff ? wstrb_ff : I_WSTRB;
  assign start_req = do_wr && (wr_addr == ADDR_W'(`FAD_OFS_CTRL)) && wr_strb[0] && wr_data[`FAD_CTRL_START];
  assign clr_req = do_wr && (wr_addr == ADDR_W'(`FAD_OFS_CTRL)) && wr_strb[0] && wr_data[`FAD_CTRL_CLR];
  // A start while busy is ignored
  assign start_ok = start_req && !tmr_busy && dif.valid;

  always_comb
  begin
    nxt_aw_held = aw_held_ff;
    nxt_awaddr = awaddr_ff;
    nxt_w_held = w_held_ff;
    nxt_wdata = wdata_ff;
    nxt_wstrb = wstrb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    nxt_insn = insn_ff;
    nxt_mode = mode_ff;
    if (bvalid_ff && I_BREADY)
    begin
      nxt_bvalid = 1'b0;
    end
    if (do_wr)
    begin
      nxt_aw_held = 1'b0;
      nxt_w_held = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = `FAD_RESP_OK;
      if (wr_addr == ADDR_W'(`FAD_OFS_INSN))
      begin
        for (int i = 0; i < 4; i++)
        begin
          if (wr_strb[i])
          begin
            nxt_insn[8*i +: 8] = wr_data[8*i +: 8];
          end
        end
      end
      else if (wr_addr == ADDR_W'(`FAD_OFS_CTRL))
      begin
        if (wr_strb[0])
        begin
          nxt_mode = wr_data[`FAD_CTRL_MODE];
        end
      end
      else if (wr_addr != ADDR_W'(`FAD_OFS_STAT) && wr_addr != ADDR_W'(`FAD_OFS_FLD))
      begin
        nxt_bresp = `FAD_RESP_ERR;
      end
    end
    else
    begin
      if (I_AWVALID && O_AWREADY)
      begin
        nxt_aw_held = 1'b1;
        nxt_awaddr = I_AWADDR;
      end
      if (I_WVALID && O_WREADY)
      begin
        nxt_w_held = 1'b1;
        nxt_wdata = I_WDATA;
        nxt_wstrb = I_WSTRB;
      end
    end
  end

  // Status flags: a setting event wins over a clear in the same cycle
  always_comb
  begin
    nxt_done = done_ff;
    nxt_ill = ill_ff;
    nxt_lat_cyc = lat_cyc_ff;
    if (clr_req)
    begin
      nxt_done = 1'b0;
      nxt_ill = 1'b0;
    end
    if (tmr_done)
    begin
      nxt_done = 1'b1;
    end
    if (start_req && !tmr_busy && !dif.valid)
    begin
      nxt_ill = 1'b1;
    end
    if (start_ok)
    begin
      nxt_lat_cyc = dif.cycles;
    end
  end

  assign stat_word = {16'h0000, lat_cyc_ff, dif.cycles, dif.op, dif.valid, ill_ff, done_ff, tmr_busy};
  assign fld_word = {18'h00000, dif.mod_f, 1'b0, dif.rm_f, 1'b0, dif.reg_f,
                     dif.two_byte, dif.mem, dif.d, dif.w};

  assign O_ARREADY = !rvalid_ff;

  always_comb
  begin
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (rvalid_ff && I_RREADY)
    begin
      nxt_rvalid = 1'b0;
    end
    if (I_ARVALID && O_ARREADY)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = `FAD_RESP_OK;
      if (I_ARADDR == ADDR_W'(`FAD_OFS_INSN))
      begin
        nxt_rdata = insn_ff;
      end
      else if (I_ARADDR == ADDR_W'(`FAD_OFS_CTRL))
      begin
        nxt_rdata = {26'h0000000, mode_ff, 4'h0};
      end
      else if (I_ARADDR == ADDR_W'(`FAD_OFS_STAT))
      begin
        nxt_rdata = stat_word;
      end
      else if (I_ARADDR == ADDR_W'(`FAD_OFS_FLD))
      begin
        nxt_rdata = fld_word;
      end
      else
      begin
        nxt_rdata = 32'h0000_0000;
        nxt_rresp = `FAD_RESP_ERR;
      end
    end
  end

  always_ff @(posedge I_SYS_CLK or posedge I_RST)
  begin
    if (I_RST)
    begin
      aw_held_ff <= 1'b0;
      awaddr_ff <= '0;
      w_held_ff <= 1'b0;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `FAD_RESP_OK;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `FAD_RESP_OK;
      insn_ff <= `FAD_INSN_RST;
      mode_ff <= `FAD_MODE_RST;
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
      lat_cyc_ff <= 4'h0;
    end
    else
    begin
      aw_held_ff <= nxt_aw_held;
      awaddr_ff <= nxt_awaddr;
      w_held_ff <= nxt_w_held;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      insn_ff <= nxt_insn;
      mode_ff <= nxt_mode;
      done_ff <= nxt_done;
      ill_ff <= nxt_ill;
      lat_cyc_ff <= nxt_lat_cyc;
    end
  end

  assign O_BVALID = bvalid_ff;
  assign O_BRESP = bresp_ff;
  assign O_RVALID = rvalid_ff;
  assign O_RDATA = rdata_ff;
  assign O_RRESP = rresp_ff;
  assign O_BUSY = tmr_busy;

  cmc_count_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:0] == `FAD_OPC_CMC) |-> (dif.op == FAD_OP_CMC && dif.cycles == 4'h2))
    else $error("complement carry decoded wrongly");
  acc_flags_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:0] == `FAD_OPC_FLAGS_TO_ACC_HIGH_OP) |-> (dif.op == FAD_OP_FLAGS_TO_ACC_HIGH_OP && dif.cycles == 4'h2))
    else $error("flags to accumulator decoded wrongly");
  flags_store_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:0] == `FAD_OPC_ACC_HIGH_TO_FLAGS_OP) |-> (dif.op == FAD_OP_ACC_HIGH_TO_FLAGS_OP && dif.cycles == 4'h3))
    else $error("accumulator to flags decoded wrongly");
  flag_stack_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:0] == `FAD_OPC_POP_FLAGS_OP) |-> (dif.op == FAD_OP_POP_FLAGS_OP && dif.cycles == 4'h5))
    else $error("pop flags decoded wrongly");
  flag_push_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:0] == `FAD_OPC_PUSH_FLAGS_OP) |-> (dif.op == FAD_OP_PUSH_FLAGS_OP && dif.cycles == 4'h4))
    else $error("push flags decoded wrongly");
  task_clear_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[15:0] == {`FAD_OPC_CLTS2, `FAD_OPC_ESC}) |-> (dif.op == FAD_OP_CLEAR_TASK_SWITCHED_OP && dif.cycles == 4'h5))
    else $error("clear task switched decoded wrongly");
  mem_add_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:1] == 7'h00 && insn_ff[15:14] != 2'h3) |-> (dif.cycles == 4'h7 && dif.mem))
    else $error("add to memory has wrong count");
  dir_width_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (insn_ff[7:2] == `FAD_TOP6_ADC) |-> (dif.d == insn_ff[1] && dif.w == insn_ff[0]))
    else $error("direction or width bit lost");
  mode_free_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    ($changed(mode_ff) && $stable(insn_ff)) |-> $stable(dif.cycles))
    else $error("count changed with mode");
  run_len_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    (start_ok && dif.cycles == 4'h3) |=> tmr_busy [*3] ##1 (!tmr_busy && tmr_done) ##1 done_ff)
    else $error("three-clock run has wrong length");
  wr_resp_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    do_wr |=> O_BVALID)
    else $error("write response missing");
endmodule : fad_top

//--- verif/tb_fad_top.sv
/*
  Self-checking bench of the opcode decoder top: AXI4-Lite traffic, decode and
  duration model. Assumes the default opcode parameters and a 200 MHz clock.
*/
`timescale 1ns/1ps
`include "fad_map.svh"
`define CHK(nm, ex, gt) begin comparisons++; if ((gt) !== (ex)) begin fail_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", nm, ex, gt); end end
module tb_fad_top;
  import fad_pkg::*;
  localparam logic [7:0] CLR_IE = 8'hF4;
  localparam logic [7:0] SET_IE = 8'hF6;
  localparam logic [7:0] SET_CY = 8'hF2;
  localparam logic [7:0] SET_DIR = 8'hF3;
  logic clk, rst, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
  logic [7:0] awaddr, araddr, b1;
  logic [31:0] wdata, rdata, v;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int fail_count, comparisons, busy_cnt, cyc_count;
  integer seed;
  logic [7:0] tab [$] = '{8'hF5, 8'h9F, 8'h9E, 8'h9D, 8'h9C, 8'h0F, 8'hF4, 8'hF6, 8'hF2, 8'hF3, 8'h00, 8'h01,
    8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h28, 8'h29,
    8'h2A, 8'h2B, 8'h80, 8'h81, 8'h82, 8'h83, 8'hFE, 8'hFF, 8'h40, 8'h47, 8'hF0, 8'h90};

  fad_top #(.ADDR_W(8), .CLR_IE_OPC(CLR_IE), .SET_IE_OPC(SET_IE), .SET_CY_OPC(SET_CY), .SET_DIR_OPC(SET_DIR))
  fad_top_inst (.I_SYS_CLK(clk), .I_RST(rst), .I_AWADDR(awaddr), .I_AWVALID(awvalid), .O_AWREADY(awready),
    .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready),
    .O_RDATA(rdata), .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .O_BUSY(busy));

  always #2.5 clk = ~clk;

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // Busy length tally and run ceiling
  always @(posedge clk)
  begin
    if (busy === 1'b1)
      busy_cnt++;
    cyc_count++;
    if (cyc_count == 40000)
    begin
      fail_count++;
      $display("timeout");
      give_verdict();
    end
  end

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] rs);
    logic pa;
    logic pw;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge clk);
      if (pa && awready === 1'b1)
      begin
        pa = 1'b0;
        awvalid <= 1'b0;
      end
      if (pw && wready === 1'b1)
      begin
        pw = 1'b0;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1)
      @(posedge clk);
    rs = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge clk);
    while (arready !== 1'b1)
      @(posedge clk);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1)
      @(posedge clk);
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  // Reference decode: {valid, op, clocks}
  function automatic logic [8:0] model(input logic [7:0] b0, input logic [7:0] s);
    logic m;
    m = (s[7:6] != 2'h3);
    if (b0 == 8'hF5) return {1'b1, FAD_OP_CMC, 4'h2};
    if (b0 == 8'h9F) return {1'b1, FAD_OP_FLAGS_TO_ACC_HIGH_OP, 4'h2};
    if (b0 == 8'h9E) return {1'b1, FAD_OP_ACC_HIGH_TO_FLAGS_OP, 4'h3};
    if (b0 == 8'h9D) return {1'b1, FAD_OP_POP_FLAGS_OP, 4'h5};
    if (b0 == 8'h9C) return {1'b1, FAD_OP_PUSH_FLAGS_OP, 4'h4};
    if (b0 == 8'h0F) return (s == 8'h06) ? {1'b1, FAD_OP_CLEAR_TASK_SWITCHED_OP, 4'h5} : 9'h000;
    if (b0 == CLR_IE) return {1'b1, FAD_OP_CLI, 4'h3};
    if (b0 == SET_IE) return {1'b1, FAD_OP_STI, 4'h3};
    if (b0 == SET_CY) return {1'b1, FAD_OP_STC, 4'h2};
    if (b0 == SET_DIR) return {1'b1, FAD_OP_STD, 4'h2};
    if (b0[7:1] == 7'h02) return {1'b1, FAD_OP_ADD, 4'h2};
    if (b0[7:1] == 7'h0A) return {1'b1, FAD_OP_ADC, 4'h2};
    if (b0[7:2] == 6'h00) return {1'b1, FAD_OP_ADD, m ? (b0[1] ? 4'h6 : 4'h7) : 4'h2};
    if (b0[7:2] == 6'h04) return {1'b1, FAD_OP_ADC, m ? (b0[1] ? 4'h6 : 4'h7) : 4'h2};
    if (b0[7:2] == 6'h20 && s[5:3] == 3'h0) return {1'b1, FAD_OP_ADD, m ? 4'h7 : 4'h2};
    if (b0[7:2] == 6'h20 && s[5:3] == 3'h2) return {1'b1, FAD_OP_ADC, m ? 4'h7 : 4'h2};
    if (b0[7:1] == 7'h7F && s[5:3] == 3'h0) return {1'b1, FAD_OP_INC, m ? 4'h6 : 4'h2};
    if (b0[7:3] == 5'h08) return {1'b1, FAD_OP_INC, 4'h2};
    if (b0[7:2] == 6'h0A && !m) return {1'b1, FAD_OP_SUB, 4'h2};
    return 9'h000;
  endfunction : model

  task automatic check_insn(input logic [7:0] b0, input logic [7:0] s);
    logic [8:0] e;
    logic [1:0] md;
    e = model(b0, s);
    md = 2'($random(seed));
    axi_wr(8'h00, {16'($random(seed)), s, b0}, 4'hF, r);
    axi_rd(8'h08, v, r);
    `CHK("decode valid", e[8], v[3])
    if (e[8])
    begin
      `CHK("op class", e[7:4], v[7:4])
      `CHK("clock count", e[3:0], v[11:8])
    end
    if (e[8] && (b0[7:2] == 6'h00 || b0[7:2] == 6'h04 || b0[7:2] == 6'h0A))
    begin
      axi_rd(8'h0C, v, r);
      `CHK("fields", {s[7:6], 1'b0, s[2:0], 1'b0, s[5:3], 1'b0, s[7:6] != 2'h3, b0[1:0]}, v[13:0])
    end
    if (e[8] && b0 == 8'h0F)
    begin
      axi_rd(8'h0C, v, r);
      `CHK("two byte", 4'h8, v[3:0])
    end
    busy_cnt = 0;
    axi_wr(8'h04, {26'h0, md, 4'h1}, 4'hF, r);
    while (busy !== 1'b0)
      @(posedge clk);
    axi_rd(8'h08, v, r);
    `CHK("busy length", e[8] ? e[3:0] : 4'h0, 4'(busy_cnt))
    `CHK("done illegal", {!e[8], e[8]}, v[2:1])
    if (e[8])
      `CHK("latched count", e[3:0], v[15:12])
    axi_rd(8'h04, v, r);
    `CHK("mode", md, v[5:4])
    axi_wr(8'h04, {26'h0, md, 4'h2}, 4'hF, r);
    axi_rd(8'h08, v, r);
    `CHK("cleared", 2'h0, v[2:1])
  endtask : check_insn

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = 52'h0;
    seed = 58;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    axi_rd(8'h00, v, r);
    `CHK("insn reset", 32'h0000_0000, v)
    axi_rd(8'h04, v, r);
    `CHK("ctrl reset", 32'h0000_0000, v)
    $display("test reset values done");
    foreach (tab[i])
      for (int k = 0; k < 4; k++)
      begin
        b1 = 8'($random(seed));
        b1[7:6] = (k == 0) ? 2'h3 : (k == 1) ? 2'h1 : b1[7:6];
        b1[5:3] = (k < 2) ? 3'h0 : (k == 2) ? 3'h2 : b1[5:3];
        if (tab[i] == 8'h0F && k == 3)
          b1 = 8'h06;
        check_insn(tab[i], b1);
      end
    $display("test opcode table done");
    repeat (40) check_insn(8'($random(seed)), 8'($random(seed)));
    $display("test random opcodes done");
    axi_wr(8'h00, 32'h0000_4001, 4'hF, r);
    busy_cnt = 0;
    axi_wr(8'h04, 32'h0000_0001, 4'hF, r);
    axi_wr(8'h04, 32'h0000_0001, 4'hF, r);
    while (busy !== 1'b0)
      @(posedge clk);
    `CHK("restart while busy", 4'h7, 4'(busy_cnt))
    $display("test restart while busy done");
    axi_wr(8'h00, 32'hAABB_CCDD, 4'hF, r);
    axi_wr(8'h00, 32'h1122_3344, 4'h5, r);
    axi_rd(8'h00, v, r);
    `CHK("byte strobes", 32'hAA22_CC44, v)
    axi_wr(8'h10, 32'hFFFF_FFFF, 4'hF, r);
    `CHK("unmapped write", `FAD_RESP_ERR, r)
    axi_rd(8'h10, v, r);
    `CHK("unmapped read", {`FAD_RESP_ERR, 32'h0}, {r, v})
    $display("test register bus done");
    give_verdict();
  end
endmodule : tb_fad_top
